// ---- rtl/ssi_top.sv ----
// Status lamp sequencer for a laser bar code scanner.
// Assumes pin inputs are asynchronous; decode events are clk_sys pulses.
`timescale 1ns/1ns
`default_nettype none
module ssi_top #(
  parameter int unsigned TICK_DIV = ssi_pkg::TICK_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       trig_pin,
  input  wire logic       serial_trig,
  input  wire logic       continuous_mode,
  input  wire logic       setup_mode,
  input  wire logic       fault,
  input  wire logic       good_read,
  input  wire logic       no_read,
  input  wire logic       invalid_symbol_flag,
  output logic      [2:0] lamp,
  output logic            laser_on
);
  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for pin-level inputs
  logic [1:0] trig_sync;
  logic [1:0] cont_sync;
  logic [1:0] setup_sync;
  logic [1:0] fault_sync;
  // Marks when the synchronisers hold real pin levels, not reset zeros
  logic [1:0] sync_fill;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sync_fill  <= 2'h0;
      trig_sync  <= 2'h0;
      cont_sync  <= 2'h0;
      setup_sync <= 2'h0;
      fault_sync <= 2'h0;
    end else begin
      sync_fill  <= {sync_fill[0], 1'b1};
      trig_sync  <= {trig_sync[0], trig_pin};
      cont_sync  <= {cont_sync[0], continuous_mode};
      setup_sync <= {setup_sync[0], setup_mode};
      fault_sync <= {fault_sync[0], fault};
    end
  end
  wire trig_s  = trig_sync[1];
  wire cont_s  = cont_sync[1];
  wire setup_s = setup_sync[1];
  wire fault_s = fault_sync[1];
  wire sync_ok = sync_fill[1];

  ////////////////////////////////////////////////////////////////////////////
  // Time base
  logic tick;
  ssi_tick #(.DIV(TICK_DIV)) u_tick (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .tick    (tick)
  );

  logic [ssi_pkg::TW-1:0] blink_cnt;
  logic                   blink;
  logic [ssi_pkg::TW-1:0] setup_cnt;
  logic [1:0]             setup_phase;
  wire blink_wrap = tick && (blink_cnt == ssi_pkg::TW'(ssi_pkg::BLINK_TICKS - 1));
  wire setup_wrap = tick && (setup_cnt == ssi_pkg::TW'(ssi_pkg::SETUP_TICKS - 1));
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      blink_cnt <= '0;
      blink     <= 1'b0;
    end else if (tick) begin
      blink_cnt <= blink_wrap ? '0 : blink_cnt + 1'b1;
      blink     <= blink ^ blink_wrap;
    end
  end
  // Setup sequence restarts on red each time setup mode is entered
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      setup_cnt   <= '0;
      setup_phase <= 2'h0;
    end else if (!setup_s) begin
      setup_cnt   <= '0;
      setup_phase <= 2'h0;
    end else if (tick) begin
      setup_cnt   <= setup_wrap ? '0 : setup_cnt + 1'b1;
      if (setup_wrap) begin
        setup_phase <= (setup_phase == 2'h2) ? 2'h0 : setup_phase + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequencer
  ssi_pkg::ssi_state_e    state;
  ssi_pkg::ssi_state_e    next_state;
  logic [ssi_pkg::TW-1:0] timer;
  logic [ssi_pkg::TW-1:0] next_timer;
  logic                   trig_prev;
  logic                   ser_pend;

  // Serial trigger sets a request; a hardware edge also starts a read
  wire trig_rise  = trig_s && !trig_prev;
  wire trig_start = !cont_s && (trig_rise || serial_trig || ser_pend);
  wire bad_read   = no_read || invalid_symbol_flag;
  wire timer_done = tick && (timer == '0);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      trig_prev <= 1'b0;
    end else begin
      trig_prev <= trig_s;
    end
  end

  // A serial trigger ends the read window at the next result
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ser_pend <= 1'b0;
    end else if (cont_s) begin
      ser_pend <= 1'b0;
    end else if (serial_trig) begin
      ser_pend <= 1'b1;
    end else if (good_read || bad_read) begin
      ser_pend <= 1'b0;
    end
  end

  always_comb begin
    next_state = state;
    next_timer = timer;
    if (tick && timer != '0) begin
      next_timer = timer - 1'b1;
    end
    case (state)
      ssi_pkg::SSI_WARMUP: begin
        // Mode is only judged once the synchroniser has filled
        if (sync_ok && !cont_s) begin
          next_state = ssi_pkg::SSI_IDLE;
        end else if (cont_s && good_read) begin
          next_state = ssi_pkg::SSI_GOOD;
          next_timer = ssi_pkg::TW'(ssi_pkg::RESULT_TICKS - 1);
        end else if (timer_done) begin
          next_state = ssi_pkg::SSI_ACTIVE;
        end
      end
      ssi_pkg::SSI_IDLE: begin
        if (cont_s) begin
          next_state = ssi_pkg::SSI_ACTIVE;
        end else if (trig_start) begin
          next_state = ssi_pkg::SSI_ACTIVE;
        end
      end
      ssi_pkg::SSI_ACTIVE: begin
        if (good_read) begin
          next_state = ssi_pkg::SSI_GOOD;
          next_timer = ssi_pkg::TW'(ssi_pkg::RESULT_TICKS - 1);
        end else if (bad_read && !cont_s) begin
          next_state = ssi_pkg::SSI_BAD;
          next_timer = ssi_pkg::TW'(ssi_pkg::RESULT_TICKS - 1);
        end else if (!cont_s && !trig_s && !ser_pend) begin
          next_state = ssi_pkg::SSI_IDLE;
        end
      end
      ssi_pkg::SSI_GOOD, ssi_pkg::SSI_BAD: begin
        if (timer_done) begin
          next_state = cont_s ? ssi_pkg::SSI_ACTIVE : ssi_pkg::SSI_IDLE;
        end
      end
      default: begin
        next_state = ssi_pkg::SSI_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state <= ssi_pkg::SSI_WARMUP;
      timer <= ssi_pkg::TW'(ssi_pkg::WARMUP_TICKS - 1);
    end else begin
      state <= next_state;
      timer <= next_timer;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lamp selection
  logic [2:0] setup_color;
  always_comb begin
    case (setup_phase)
      2'h0:    setup_color = ssi_pkg::LAMP_RED;
      2'h1:    setup_color = ssi_pkg::LAMP_YELLOW;
      default: setup_color = ssi_pkg::LAMP_GREEN;
    endcase
  end

  wire        laser_state = (state == ssi_pkg::SSI_ACTIVE);
  wire [2:0]  blink_yel   = blink ? ssi_pkg::LAMP_YELLOW : ssi_pkg::LAMP_OFF;
  wire [2:0]  blink_red   = blink ? ssi_pkg::LAMP_RED : ssi_pkg::LAMP_OFF;
  wire [2:0]  next_lamp   =
    fault_s ? blink_red :
    setup_s ? setup_color :
    (state == ssi_pkg::SSI_GOOD) ? ssi_pkg::LAMP_GREEN :
    (state == ssi_pkg::SSI_BAD)  ? ssi_pkg::LAMP_RED :
    laser_state ? ssi_pkg::LAMP_YELLOW :
    blink_yel;

  // Laser follows the active state only; it is never gated by the lamp
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lamp     <= ssi_pkg::LAMP_OFF;
      laser_on <= 1'b0;
    end else begin
      lamp     <= next_lamp;
      laser_on <= laser_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_good_seen;
    state == ssi_pkg::SSI_ACTIVE && good_read;
  endsequence
  sequence s_bad_seen;
    state == ssi_pkg::SSI_ACTIVE && !good_read && bad_read && !cont_s;
  endsequence

  a_good_green: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_good_seen ##1 !fault_s && !setup_s |=> lamp == ssi_pkg::LAMP_GREEN)
    else $error("good read did not light green");
  a_bad_red: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_bad_seen |=> state == ssi_pkg::SSI_BAD)
    else $error("bad read did not enter red");
  a_cont_nored: assert property (@(posedge clk_sys) disable iff (!nrst)
    cont_s && $past(cont_s) && state != ssi_pkg::SSI_BAD |=> state != ssi_pkg::SSI_BAD)
    else $error("red shown in continuous mode");
  a_laser_yel: assert property (@(posedge clk_sys) disable iff (!nrst)
    laser_on && $past(!fault_s && !setup_s && laser_state) |-> lamp == ssi_pkg::LAMP_YELLOW)
    else $error("laser on without steady yellow");
  a_fault_first: assert property (@(posedge clk_sys) disable iff (!nrst)
    fault_s |=> lamp == ssi_pkg::LAMP_RED || lamp == ssi_pkg::LAMP_OFF)
    else $error("fault not given priority");
  a_cont_ignore: assert property (@(posedge clk_sys) disable iff (!nrst)
    cont_s && state == ssi_pkg::SSI_IDLE |=> state != ssi_pkg::SSI_IDLE || !cont_s)
    else $error("continuous idle not left");
  a_trig_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    state == ssi_pkg::SSI_ACTIVE && trig_s && !good_read && !bad_read
    |=> state == ssi_pkg::SSI_ACTIVE)
    else $error("trigger held but active left");
  a_result_len: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(state == ssi_pkg::SSI_GOOD) |-> timer == ssi_pkg::TW'(ssi_pkg::RESULT_TICKS - 1))
    else $error("result timer not loaded");
  a_setup_cycle: assert property (@(posedge clk_sys) disable iff (!nrst)
    setup_phase != 2'h3)
    else $error("setup phase out of range");
  a_warm_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    state == ssi_pkg::SSI_WARMUP && sync_ok && cont_s && !timer_done && !good_read
    |=> state == ssi_pkg::SSI_WARMUP) else $error("warm-up left early");
  a_warm_end: assert property (@(posedge clk_sys) disable iff (!nrst)
    state == ssi_pkg::SSI_WARMUP && cont_s && timer_done && !good_read
    |=> state == ssi_pkg::SSI_ACTIVE) else $error("warm-up did not end in reading");
  a_idle_blink: assert property (@(posedge clk_sys) disable iff (!nrst)
    !fault_s && !setup_s && state == ssi_pkg::SSI_IDLE
    |=> lamp == $past(blink_yel)) else $error("idle lamp not blinking yellow");
  a_fault_blink: assert property (@(posedge clk_sys) disable iff (!nrst)
    fault_s
    |=> lamp == $past(blink_red)) else $error("fault lamp not blinking red");
  a_setup_show: assert property (@(posedge clk_sys) disable iff (!nrst)
    !fault_s && setup_s
    |=> lamp == $past(setup_color)) else $error("setup colour not shown");
  a_result_pri: assert property (@(posedge clk_sys) disable iff (!nrst)
    !fault_s && !setup_s && state == ssi_pkg::SSI_BAD
    |=> lamp == ssi_pkg::LAMP_RED) else $error("red result not shown");
  a_ser_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
    cont_s
    |=> !ser_pend) else $error("serial request kept in continuous mode");
  a_trig_start: assert property (@(posedge clk_sys) disable iff (!nrst)
    state == ssi_pkg::SSI_IDLE && !cont_s && trig_start
    |=> state == ssi_pkg::SSI_ACTIVE) else $error("trigger did not start a read");
  a_good_exit: assert property (@(posedge clk_sys) disable iff (!nrst)
    state == ssi_pkg::SSI_GOOD && timer_done && cont_s
    |=> state == ssi_pkg::SSI_ACTIVE) else $error("green did not return to reading");
  a_bad_exit: assert property (@(posedge clk_sys) disable iff (!nrst)
    state == ssi_pkg::SSI_BAD && timer_done && !cont_s
    |=> state == ssi_pkg::SSI_IDLE) else $error("red did not return to idle");
  a_bad_len: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(state == ssi_pkg::SSI_BAD)
    |-> timer == ssi_pkg::TW'(ssi_pkg::RESULT_TICKS - 1)) else $error("red timer not loaded");
  a_blink_tick: assert property (@(posedge clk_sys) disable iff (!nrst)
    !tick
    |=> $stable(blink)) else $error("blink moved without a tick");
  a_trig_drop: assert property (@(posedge clk_sys) disable iff (!nrst)
    state == ssi_pkg::SSI_ACTIVE && !cont_s && !trig_s && !ser_pend && !good_read && !bad_read
    |=> state == ssi_pkg::SSI_IDLE) else $error("laser stayed on after trigger");
endmodule
`default_nettype wire

// ---- rtl/ssi_pkg.sv ----
// Constants shared by the status indicator sequencer.
// Assumes a single 100 MHz system clock.
package ssi_pkg;
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned TICK_MS        = 1;
  localparam int unsigned TICK_CYCLES    = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned BLINK_HALF_MS  = 250;
  localparam int unsigned RESULT_MS      = 500;
  localparam int unsigned WARMUP_MS      = 5000;
  localparam int unsigned BLINK_TICKS    = BLINK_HALF_MS / TICK_MS;
  localparam int unsigned RESULT_TICKS   = RESULT_MS / TICK_MS;
  localparam int unsigned WARMUP_TICKS   = WARMUP_MS / TICK_MS;
  localparam int unsigned SETUP_STEP_MS  = 500;
  localparam int unsigned SETUP_TICKS    = SETUP_STEP_MS / TICK_MS;
  localparam int          TW             = 13;
  localparam logic [2:0]  LAMP_OFF       = 3'h0;
  localparam logic [2:0]  LAMP_YELLOW    = 3'h1;
  localparam logic [2:0]  LAMP_GREEN     = 3'h2;
  localparam logic [2:0]  LAMP_RED       = 3'h4;
  typedef enum logic [2:0] {
    SSI_WARMUP = 3'h0,
    SSI_IDLE   = 3'h1,
    SSI_ACTIVE = 3'h3,
    SSI_GOOD   = 3'h2,
    SSI_BAD    = 3'h6
  } ssi_state_e;
endpackage

// ---- rtl/ssi_tick.sv ----
// Prescaler producing a one-cycle tick enable.
// Assumes one clock domain, clk_sys.
`timescale 1ns/1ns
`default_nettype none
module ssi_tick #(
  parameter int unsigned DIV = ssi_pkg::TICK_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic nrst,
  output logic      tick
);
  logic [31:0] cnt;
  wire         wrap = (cnt == 32'(DIV - 1));
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt  <= 32'h0;
      tick <= 1'b0;
    end else begin
      cnt  <= wrap ? 32'h0 : cnt + 32'h1;
      tick <= wrap;
    end
  end
endmodule
`default_nettype wire

// ---- bench/ssi_trig_src.sv ----
// Model of the trigger sources: a photo sensor and a serial link.
// Assumes the bench moves object_present and send_char at clk_sys edges.
`timescale 1ns/1ns
`default_nettype none
module ssi_trig_src (
  input  wire logic clk_sys,
  input  wire logic object_present,
  input  wire logic send_char,
  output var logic  trig_pin,
  output var logic  serial_trig
);
  initial begin
    trig_pin = 1'b0;
    serial_trig = 1'b0;
  end
  // Sensor output stays active while the object blocks the beam
  always @(posedge clk_sys) begin
    trig_pin <= object_present;
    serial_trig <= send_char;
  end
endmodule
`default_nettype wire

// ---- bench/scan_status_indicator_tb.sv ----
// Self-checking bench for the status lamp sequencer.
// Assumes TICK_DIV of 10, so 1 ms is 10 clk_sys cycles.
`timescale 1ns/1ns
`default_nettype none
module scan_status_indicator_tb;
  logic       clk_sys = 1'b0;
  logic       nrst = 1'b0;
  logic       obj = 1'b0;
  logic       send_char = 1'b0;
  logic       continuous_mode = 1'b0;
  logic       setup_mode = 1'b0;
  logic       fault = 1'b0;
  logic       good_read = 1'b0;
  logic       no_read = 1'b0;
  logic       invalid_symbol_flag = 1'b0;
  logic       trig_pin;
  logic       serial_trig;
  logic [2:0] lamp;
  logic       laser_on;
  int         fail_count = 0;
  int         cmp_count = 0;
  int         cycles = 0;

  always #5 clk_sys = ~clk_sys;

  ssi_trig_src src (.clk_sys(clk_sys), .object_present(obj), .send_char(send_char),
                    .trig_pin(trig_pin), .serial_trig(serial_trig));
  ssi_top #(.TICK_DIV(10)) dut (.clk_sys(clk_sys), .nrst(nrst), .trig_pin(trig_pin),
    .serial_trig(serial_trig), .continuous_mode(continuous_mode), .setup_mode(setup_mode),
    .fault(fault), .good_read(good_read), .no_read(no_read),
    .invalid_symbol_flag(invalid_symbol_flag), .lamp(lamp), .laser_on(laser_on));

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard: the whole run needs about 89500 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 95000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic chk(input string what, input logic [2:0] exp, input logic [2:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic do_reset;
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
  endtask

  // Decode outcome pulse, one clk_sys cycle: 0 good, 1 no read, 2 invalid
  task automatic evt(input int k);
    @(posedge clk_sys);
    good_read <= (k == 0);
    no_read <= (k == 1);
    invalid_symbol_flag <= (k == 2);
    @(posedge clk_sys);
    {good_read, no_read, invalid_symbol_flag} <= 3'h0;
  endtask

  task automatic serial_char;
    @(posedge clk_sys);
    send_char <= 1'b1;
    @(posedge clk_sys);
    send_char <= 1'b0;
  endtask

  // Samples every 250 cycles; a blink must show both the colour and off
  task automatic watch(input logic [2:0] col, input logic steady, input int span);
    logic on;
    logic off;
    on = 1'b0;
    off = 1'b0;
    for (int i = 0; i < span; i += 250) begin
      cyc(250);
      on |= (lamp === col);
      off |= (lamp === ssi_pkg::LAMP_OFF);
      if (steady) chk("lamp", col, lamp);
      else chk("lamp", (lamp === ssi_pkg::LAMP_OFF) ? ssi_pkg::LAMP_OFF : col, lamp);
      if (col == ssi_pkg::LAMP_YELLOW) chk("laser", {2'h0, steady}, {2'h0, laser_on});
    end
    if (!steady) chk("blink phases", 3'h3, {1'b0, on, off});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_trigger;
    watch(ssi_pkg::LAMP_YELLOW, 1'b0, 3000);
    @(posedge clk_sys);
    obj <= 1'b1;
    cyc(12);
    chk("laser", 3'h1, {2'h0, laser_on});
    watch(ssi_pkg::LAMP_YELLOW, 1'b1, 500);
    evt(0);
    cyc(3);
    chk("lamp", ssi_pkg::LAMP_GREEN, lamp);
    chk("laser", 3'h0, {2'h0, laser_on});
    @(posedge clk_sys);
    obj <= 1'b0;
    cyc(4890);
    chk("lamp", ssi_pkg::LAMP_GREEN, lamp);
    cyc(200);
    watch(ssi_pkg::LAMP_YELLOW, 1'b0, 3000);
  endtask

  task automatic t_red;
    serial_char();
    cyc(8);
    chk("laser", 3'h1, {2'h0, laser_on});
    evt(1);
    cyc(3);
    chk("lamp", ssi_pkg::LAMP_RED, lamp);
    cyc(4890);
    chk("lamp", ssi_pkg::LAMP_RED, lamp);
    cyc(200);
    chk("red ended", 3'h1, {2'h0, lamp !== ssi_pkg::LAMP_RED});
    @(posedge clk_sys);
    obj <= 1'b1;
    cyc(12);
    evt(2);
    @(posedge clk_sys);
    obj <= 1'b0;
    cyc(2);
    chk("lamp", ssi_pkg::LAMP_RED, lamp);
  endtask

  // Setup is entered while the red result still shows
  task automatic t_setup_fault;
    @(posedge clk_sys);
    setup_mode <= 1'b1;
    cyc(2500);
    chk("lamp", ssi_pkg::LAMP_RED, lamp);
    cyc(5000);
    chk("lamp", ssi_pkg::LAMP_YELLOW, lamp);
    cyc(5000);
    chk("lamp", ssi_pkg::LAMP_GREEN, lamp);
    @(posedge clk_sys);
    fault <= 1'b1;
    cyc(10);
    watch(ssi_pkg::LAMP_RED, 1'b0, 3000);
    @(posedge clk_sys);
    fault <= 1'b0;
    setup_mode <= 1'b0;
  endtask

  task automatic t_continuous;
    continuous_mode <= 1'b1;
    do_reset();
    watch(ssi_pkg::LAMP_YELLOW, 1'b0, 3000);
    cyc(47100);
    watch(ssi_pkg::LAMP_YELLOW, 1'b1, 500);
    serial_char();
    @(posedge clk_sys);
    obj <= 1'b1;
    evt(1);
    watch(ssi_pkg::LAMP_YELLOW, 1'b1, 1000);
    @(posedge clk_sys);
    obj <= 1'b0;
    evt(0);
    cyc(3);
    chk("lamp", ssi_pkg::LAMP_GREEN, lamp);
    cyc(4890);
    chk("lamp", ssi_pkg::LAMP_GREEN, lamp);
    cyc(200);
    watch(ssi_pkg::LAMP_YELLOW, 1'b1, 500);
  endtask

  initial begin
    do_reset();
    t_trigger();
    t_red();
    t_setup_fault();
    t_continuous();
    give_verdict();
  end
endmodule
`default_nettype wire
